// >>> logic/spw_pkg.sv
// package: constants and types shared by the pwm output port target and its bus controller
package spw_pkg;
    localparam int SPW_CHANNELS = 6;
    localparam int SPW_LEVEL_W = 7;
    localparam logic [6:0] SPW_ADDR_BASE = 7'h38;
    localparam logic [1:0] SPW_SEL_CMD = 2'h0;
    localparam logic [1:0] SPW_SEL_RAM = 2'h1;
    localparam logic [1:0] SPW_SEL_PWM = 2'h2;
    localparam logic [1:0] SPW_SEL_NONE = 2'h3;
    localparam int SPW_CTRL_MORE_BIT = 7;
    localparam int SPW_CTRL_SEL_HI = 6;
    localparam int SPW_CTRL_SEL_LO = 5;
    localparam logic [7:0] SPW_CMD_LOAD_PTR = 8'hE0;
    localparam logic [7:0] SPW_CMD_LOAD_PTR_MASK = 8'hF8;
    localparam logic [1:0] SPW_MODE_LCD = 2'h0;
    localparam logic [1:0] SPW_MODE_LOW = 2'h1;
    localparam logic [1:0] SPW_MODE_HIGH = 2'h2;
    localparam logic [1:0] SPW_MODE_PWM = 2'h3;
    localparam int SPW_LINK_DIV = 16;
    localparam logic [7:0] SPW_OFF_CMD = 8'h00;
    localparam logic [7:0] SPW_OFF_STATUS = 8'h04;
    localparam logic [1:0] SPW_HTRANS_IDLE = 2'h0;
    localparam logic [1:0] SPW_HTRANS_NONSEQ = 2'h2;
    typedef logic [6:0] spw_level_type;
endpackage

// >>> logic/spw_link_if.sv
// interface: two-wire link between bus controller and pwm target
`timescale 1ns/1ps
interface spw_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o) ? 1'b0 : 1'b1;
    modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (input scl, input sda, output scl_o, output scl_oe,
        output sda_host_o, output sda_host_oe);
endinterface

// >>> logic/spw_pwm_channel.sv
// one pwm channel: frame-latched level compare, output mode select
`timescale 1ns/1ps
module spw_pwm_channel
    import spw_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // timing
    input wire logic frame_start,
    input wire logic [6:0] slot_count,
    input wire logic invert,
    // settings
    input wire logic [6:0] level,
    input wire logic [1:0] mode,
    input wire logic segment_in,
    // pin
    output logic pin_out
);
    import spw_pkg::*;
    logic [6:0] active_reg, active_next;
    logic pin_reg, pin_next;
    logic wave;

    always_comb
    begin
        active_next = frame_start ? level : active_reg;
        wave = (slot_count < active_reg) ^ invert;
        case (mode)
            SPW_MODE_LCD: pin_next = segment_in;
            SPW_MODE_LOW: pin_next = 1'b0;
            SPW_MODE_HIGH: pin_next = 1'b1;
            SPW_MODE_PWM: pin_next = wave;
            default: pin_next = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            active_reg <= 7'h00;
            pin_reg <= 1'b0;
        end
        else
        begin
            active_reg <= active_next;
            pin_reg <= pin_next;
        end
    end
    assign pin_out = pin_reg;
endmodule

// >>> logic/spw_target.sv
// pwm output port target: two-wire write receiver, control byte decoder, six pwm outputs
`timescale 1ns/1ps
module spw_target
    import spw_pkg::*;
#(
    parameter int CHANNELS = 6
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link
    spw_link_if.device link,
    // straps and timebase
    input wire logic address_strap_pin,
    input wire logic slot_tick,
    // per-output modes, shared invert bit and per-output segment signals
    input wire logic [2*CHANNELS-1:0] output_mode,
    input wire logic waveform_invert_bit,
    input wire logic [CHANNELS-1:0] segment_signals,
    // outputs
    output logic [CHANNELS-1:0] general_output_pins,
    output logic [7:0] cmd_byte,
    output logic cmd_valid,
    output logic [7:0] ram_byte,
    output logic ram_valid
);
    import spw_pkg::*;
    typedef enum {ST_IDLE, ST_ADDR, ST_CTRL, ST_DATA, ST_IGNORE} spw_state_type;

    logic [1:0] scl_sync_reg, sda_sync_reg, scl_sync_next, sda_sync_next;
    logic scl_d_reg, sda_d_reg, scl_d_next, sda_d_next;
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    spw_state_type state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic ack_reg, ack_next;
    logic [1:0] strap_sync_reg, strap_sync_next;
    logic [1:0] sel_reg, sel_next;
    logic ctrl_done_reg, ctrl_done_next;
    logic [2:0] ptr_reg, ptr_next;
    logic [6:0] level_reg [CHANNELS], level_next [CHANNELS];
    logic [7:0] cmd_reg, cmd_next, ram_reg, ram_next;
    logic cmdv_reg, cmdv_next, ramv_reg, ramv_next;
    logic [6:0] slot_reg, slot_next;
    logic frame_start;
    logic [7:0] rx_byte;

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    assign rx_byte = {shift_reg[6:0], sda_s};
    assign frame_start = slot_tick && (slot_reg == 7'h7F);

    always_comb
    begin
        scl_sync_next = {scl_sync_reg[0], link.scl};
        sda_sync_next = {sda_sync_reg[0], link.sda};
        scl_d_next = scl_s;
        sda_d_next = sda_s;
        slot_next = slot_tick ? slot_reg + 7'h01 : slot_reg;
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        ack_next = ack_reg;
        strap_sync_next = {strap_sync_reg[0], address_strap_pin};
        sel_next = sel_reg;
        ctrl_done_next = ctrl_done_reg;
        ptr_next = ptr_reg;
        level_next = level_reg;
        cmd_next = cmd_reg;
        ram_next = ram_reg;
        cmdv_next = 1'b0;
        ramv_next = 1'b0;
        if (start_det)
        begin
            state_next = ST_ADDR;
            bit_next = 4'h0;
            ack_next = 1'b0;
            ctrl_done_next = 1'b0;
        end
        else if (stop_det)
        begin
            state_next = ST_IDLE;
            ack_next = 1'b0;
        end
        else if (state_reg != ST_IDLE && state_reg != ST_IGNORE)
        begin
            if (scl_rise && bit_reg < 4'h8)
            begin
                shift_next = rx_byte;
                if (bit_reg == 4'h7)
                begin
                    case (state_reg)
                        ST_ADDR:
                        begin
                            // write-only target; read requests are not acknowledged
                            if (rx_byte[7:1] == {SPW_ADDR_BASE[6:1], strap_sync_reg[1]}
                                && !rx_byte[0])
                                state_next = ST_CTRL;
                            else
                                state_next = ST_IGNORE;
                        end
                        ST_CTRL:
                        begin
                            sel_next = rx_byte[SPW_CTRL_SEL_HI:SPW_CTRL_SEL_LO];
                            ctrl_done_next = !rx_byte[SPW_CTRL_MORE_BIT];
                            state_next = ST_DATA;
                        end
                        ST_DATA:
                        begin
                            case (sel_reg)
                                SPW_SEL_CMD:
                                begin
                                    cmd_next = rx_byte;
                                    cmdv_next = 1'b1;
                                    if ((rx_byte & SPW_CMD_LOAD_PTR_MASK) == SPW_CMD_LOAD_PTR)
                                        ptr_next = rx_byte[2:0];
                                end
                                SPW_SEL_RAM:
                                begin
                                    ram_next = rx_byte;
                                    ramv_next = 1'b1;
                                end
                                SPW_SEL_PWM:
                                begin
                                    // a pointer loaded past the last channel writes nothing
                                    if (int'(ptr_reg) < CHANNELS)
                                        level_next[ptr_reg] = rx_byte[6:0];
                                    ptr_next = (int'(ptr_reg) >= CHANNELS - 1) ? 3'h0
                                        : ptr_reg + 3'h1;
                                end
                                default: ;
                            endcase
                            if (!ctrl_done_reg)
                                state_next = ST_CTRL;
                        end
                        default: ;
                    endcase
                end
                bit_next = bit_reg + 4'h1;
            end
            else if (scl_fall && bit_reg == 4'h8)
                ack_next = (state_reg != ST_IGNORE) && (state_next != ST_IGNORE);
            else if (scl_fall && bit_reg == 4'h9)
            begin
                ack_next = 1'b0;
                bit_next = 4'h0;
            end
            else if (scl_rise && bit_reg == 4'h8)
                bit_next = 4'h9;
        end
        if (state_reg == ST_IGNORE && ack_reg && scl_fall)
            ack_next = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            slot_reg <= 7'h00;
            state_reg <= ST_IDLE;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            ack_reg <= 1'b0;
            strap_sync_reg <= 2'h0;
            sel_reg <= SPW_SEL_CMD;
            ctrl_done_reg <= 1'b0;
            ptr_reg <= 3'h0;
            for (int i = 0; i < CHANNELS; i++)
                level_reg[i] <= 7'h00;
            cmd_reg <= 8'h00;
            ram_reg <= 8'h00;
            cmdv_reg <= 1'b0;
            ramv_reg <= 1'b0;
        end
        else
        begin
            scl_sync_reg <= scl_sync_next;
            sda_sync_reg <= sda_sync_next;
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
            slot_reg <= slot_next;
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            ack_reg <= ack_next;
            strap_sync_reg <= strap_sync_next;
            sel_reg <= sel_next;
            ctrl_done_reg <= ctrl_done_next;
            ptr_reg <= ptr_next;
            level_reg <= level_next;
            cmd_reg <= cmd_next;
            ram_reg <= ram_next;
            cmdv_reg <= cmdv_next;
            ramv_reg <= ramv_next;
        end
    end

    // open drain: only ever pulls low, and only for acknowledge
    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe = ack_reg;
    assign cmd_byte = cmd_reg;
    assign cmd_valid = cmdv_reg;
    assign ram_byte = ram_reg;
    assign ram_valid = ramv_reg;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : gen_ch
            spw_pwm_channel u_ch (
                .hclk(hclk),
                .hresetn(hresetn),
                .frame_start(frame_start),
                .slot_count(slot_reg),
                .invert(waveform_invert_bit),
                .level(level_reg[g]),
                .mode(output_mode[2*g +: 2]),
                .segment_in(segment_signals[g]),
                .pin_out(general_output_pins[g])
            );
        end
    endgenerate
endmodule

// >>> logic/spw_host.sv
// bus controller end: ahb-lite command registers drive single-byte link writes
`timescale 1ns/1ps
module spw_host
    import spw_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // link
    spw_link_if.host link
);
    import spw_pkg::*;
    typedef enum {HS_IDLE, HS_START, HS_BIT, HS_STOP} spw_hstate_type;
    // command word: [7:0] byte, [8] start before, [9] stop after
    spw_hstate_type st_reg, st_next;
    logic [3:0] div_reg, div_next;
    logic [1:0] ph_reg, ph_next;
    logic [3:0] bit_reg, bit_next;
    logic [8:0] sh_reg, sh_next;
    logic stop_reg, stop_next, nack_reg, nack_next;
    logic scl_reg, scl_next, sda_reg, sda_next;
    // the data line is a pin: two flops before the nack sample reads it
    logic [1:0] sda_sync_reg, sda_sync_next;
    logic wr_reg, wr_next, addr_phase;
    logic [7:0] adr_reg, adr_next;
    logic [31:0] rd_reg, rd_next;
    logic tick, busy;

    assign tick = div_reg == 4'(SPW_LINK_DIV / 4 - 1);
    assign busy = st_reg != HS_IDLE;

    always_comb
    begin
        div_next = tick ? 4'h0 : div_reg + 4'h1;
        st_next = st_reg;
        ph_next = ph_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        stop_next = stop_reg;
        nack_next = nack_reg;
        scl_next = scl_reg;
        sda_next = sda_reg;
        sda_sync_next = {sda_sync_reg[0], link.sda};
        addr_phase = htrans == SPW_HTRANS_NONSEQ && hsel;
        wr_next = addr_phase && hwrite;
        adr_next = addr_phase ? haddr[7:0] : adr_reg;
        rd_next = {30'h0, nack_reg, busy};
        if (wr_reg && adr_reg == SPW_OFF_CMD && !busy)
        begin
            sh_next = {hwdata[7:0], 1'b1};
            stop_next = hwdata[9];
            st_next = hwdata[8] ? HS_START : HS_BIT;
            ph_next = 2'h0;
            bit_next = 4'h0;
        end
        else if (tick)
        begin
            case (st_reg)
                HS_START:
                begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0:
                        begin
                            sda_next = 1'b1;
                            scl_next = 1'b1;
                        end
                        2'h1: sda_next = 1'b0;
                        2'h2: scl_next = 1'b0;
                        default: st_next = HS_BIT;
                    endcase
                end
                HS_BIT:
                begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: sda_next = sh_reg[8];
                        2'h1: scl_next = 1'b1;
                        2'h2:
                        begin
                            if (bit_reg == 4'h8)
                                nack_next = sda_sync_reg[1];
                        end
                        default:
                        begin
                            scl_next = 1'b0;
                            sh_next = {sh_reg[7:0], 1'b1};
                            bit_next = bit_reg + 4'h1;
                            if (bit_reg == 4'h8)
                                st_next = stop_reg ? HS_STOP : HS_IDLE;
                        end
                    endcase
                end
                HS_STOP:
                begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: sda_next = 1'b0;
                        2'h1: scl_next = 1'b1;
                        2'h2: sda_next = 1'b1;
                        default: st_next = HS_IDLE;
                    endcase
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg <= HS_IDLE;
            div_reg <= 4'h0;
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            sh_reg <= 9'h1FF;
            stop_reg <= 1'b0;
            nack_reg <= 1'b0;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            wr_reg <= 1'b0;
            sda_sync_reg <= 2'h3;
            adr_reg <= 8'h00;
            rd_reg <= 32'h0;
        end
        else
        begin
            st_reg <= st_next;
            div_reg <= div_next;
            ph_reg <= ph_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            stop_reg <= stop_next;
            nack_reg <= nack_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            wr_reg <= wr_next;
            sda_sync_reg <= sda_sync_next;
            adr_reg <= adr_next;
            rd_reg <= rd_next;
        end
    end

    assign hrdata = rd_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // open-drain style: drive low only, release for high
    assign link.scl_o = 1'b0;
    assign link.scl_oe = !scl_reg;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = !sda_reg;
endmodule

// >>> testbench/spw_link_chk.sv
// checker: link protocol properties between the pwm target and the bus controller
`timescale 1ns/1ps
module spw_link_chk
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // address strap
    input wire logic strap,
    // link wires and drivers
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe
);
    logic scl_q;
    logic sda_q;
    logic first_q;
    logic addr_ok_q;
    logic busy_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic rise;
    logic start_c;
    logic stop_c;
    assign rise = scl && !scl_q;
    assign start_c = scl && scl_q && sda_q && !sda;
    assign stop_c = scl && scl_q && !sda_q && sda;
    // counts on the resolved wires, so it runs ahead of the target's own synchroniser
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            first_q <= 1'b0;
            addr_ok_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_c)
            begin
                cnt_q <= 4'h0;
                first_q <= 1'b1;
                addr_ok_q <= 1'b0;
                busy_q <= 1'b1;
            end
            else if (stop_c)
                busy_q <= 1'b0;
            else if (rise)
            begin
                cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
                if (cnt_q < 4'h8)
                    sh_q <= {sh_q[6:0], sda};
                if (cnt_q == 4'h8 && first_q)
                    addr_ok_q <= !sda;
                if (cnt_q == 4'h8)
                    first_q <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_dev_open_drain:
        assert property (sda_dev_o == 1'b0)
        else $error("target drove the data line high");
    a_host_open_drain:
        assert property (scl_o == 1'b0 && sda_host_o == 1'b0)
        else $error("controller drove a line high");
    a_ack_window:
        assert property (sda_dev_oe |-> cnt_q == 4'h9 || (cnt_q == 4'h8 && !(scl && scl_q)))
        else $error("target pulled data outside the acknowledge bit");
    a_ack_held_high:
        assert property (cnt_q == 4'h9 && scl && scl_q && $past(sda_dev_oe) |-> sda_dev_oe)
        else $error("acknowledge released while clock high");
    a_ack_data_byte:
        assert property (rise && cnt_q == 4'h8 && !first_q && addr_ok_q |-> !sda)
        else $error("data byte not acknowledged");
    a_ignore_foreign:
        assert property (rise && cnt_q == 4'h8 && first_q
            && (sh_q[0] || sh_q[7:1] != {6'h1C, strap}) |-> sda)
        else $error("foreign or read address acknowledged");
    a_start_when_free:
        assert property (start_c |-> !busy_q)
        else $error("start while the bus was busy");
    a_idle_clock_high:
        assert property (!busy_q |-> scl)
        else $error("clock low while the bus is free");
    a_data_stable_high:
        assert property (scl && scl_q && busy_q && !stop_c |-> sda == sda_q)
        else $error("data changed while clock high");
endmodule

// >>> testbench/six_channel_pwm_output_port_tb.sv
// testbench: both link ends joined, ahb-lite stimulus, decoded bytes and pwm pins checked
`timescale 1ns/1ps
module six_channel_pwm_output_port_tb;
    import spw_pkg::*;
    typedef struct {
        logic [11:0] modes;
        logic [5:0] seg;
        logic inv;
        int hi [6];
    } spw_row_type;
    logic hclk = 1'b0;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic strap;
    logic slot_tick = 1'b0;
    logic [1:0] tick_div = 2'h0;
    logic [11:0] modes;
    logic invert;
    logic [5:0] segs;
    logic [5:0] pins;
    logic [7:0] cmd_byte;
    logic cmd_valid;
    logic [7:0] ram_byte;
    logic ram_valid;
    logic [7:0] acc [$];
    logic [7:0] cmd_q [$];
    logic [7:0] ram_q [$];
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    // expected high slots per frame; the seventh pwm byte wraps onto channel 0
    spw_row_type rows [6] = '{
        '{{6{SPW_MODE_LCD}}, 6'h15, 1'b0, '{128, 0, 128, 0, 128, 0}},
        '{{6{SPW_MODE_LOW}}, 6'h3F, 1'b1, '{0, 0, 0, 0, 0, 0}},
        '{{6{SPW_MODE_HIGH}}, 6'h00, 1'b1, '{128, 128, 128, 128, 128, 128}},
        '{{6{SPW_MODE_PWM}}, 6'h3F, 1'b0, '{0, 1, 64, 126, 127, 5}},
        '{{6{SPW_MODE_PWM}}, 6'h00, 1'b1, '{128, 127, 64, 2, 1, 123}},
        '{{SPW_MODE_PWM, SPW_MODE_LCD, SPW_MODE_PWM, SPW_MODE_HIGH, SPW_MODE_LOW, SPW_MODE_LCD},
            6'h11, 1'b0, '{128, 0, 128, 126, 128, 5}}};
    spw_link_if i_spw_link_if ();
    spw_host i_spw_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(i_spw_link_if.host));
    spw_target #(.CHANNELS(SPW_CHANNELS)) i_spw_target (.hclk(hclk), .hresetn(hresetn),
        .link(i_spw_link_if.device), .address_strap_pin(strap), .slot_tick(slot_tick),
        .output_mode(modes), .waveform_invert_bit(invert), .segment_signals(segs),
        .general_output_pins(pins), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
        .ram_byte(ram_byte), .ram_valid(ram_valid));
    spw_link_chk i_spw_link_chk (.hclk(hclk), .hresetn(hresetn), .strap(strap),
        .scl(i_spw_link_if.scl),
        .sda(i_spw_link_if.sda), .scl_o(i_spw_link_if.scl_o), .scl_oe(i_spw_link_if.scl_oe),
        .sda_host_o(i_spw_link_if.sda_host_o), .sda_host_oe(i_spw_link_if.sda_host_oe),
        .sda_dev_o(i_spw_link_if.sda_dev_o), .sda_dev_oe(i_spw_link_if.sda_dev_oe));
    always #2 hclk = ~hclk;
    always @(posedge hclk)
    begin
        tick_div <= tick_div + 2'h1;
        slot_tick <= (tick_div == 2'h3);
        cycles <= cycles + 1;
        if (cmd_valid === 1'b1)
            cmd_q.push_back(cmd_byte);
        if (ram_valid === 1'b1)
            ram_q.push_back(ram_byte);
        if (cycles == 30000)
        begin
            bad_count++;
            $display("[ERR] %0t run timed out", $time);
            complete_run();
        end
    end
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= SPW_HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= SPW_HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // one access: start before the first byte, stop after the last, then read the ack flag
    task automatic access(output logic nack);
        logic [31:0] rd;
        cmd_q.delete();
        ram_q.delete();
        foreach (acc[i])
        begin
            rd = 32'h1;
            while (rd[0] !== 1'b0)
                ahb(1'b0, SPW_OFF_STATUS, 32'h0, rd);
            ahb(1'b1, SPW_OFF_CMD, {22'h0, i == acc.size() - 1, i == 0, acc[i]}, rd);
        end
        rd = 32'h1;
        while (rd[0] !== 1'b0)
            ahb(1'b0, SPW_OFF_STATUS, 32'h0, rd);
        nack = rd[1];
    endtask
    task automatic measure(input spw_row_type r);
        logic [5:0] prev;
        logic [5:0] cur;
        logic [5:0] edge_m;
        int hi [6];
        @(posedge hclk);
        modes <= r.modes;
        segs <= r.seg;
        invert <= r.inv;
        hi = '{0, 0, 0, 0, 0, 0};
        // a new level only lands at a frame boundary, so let one whole frame pass
        repeat (600) @(posedge hclk);
        prev = pins;
        repeat (128)
        begin
            repeat (4) @(posedge hclk);
            cur = pins;
            check(!$isunknown(cur), "pin unknown");
            edge_m = r.inv ? (prev & ~cur) : (cur & ~prev);
            if (r.modes === {6{SPW_MODE_PWM}})
                check(edge_m === 6'h00 || edge_m === 6'h3E, "pwm edges not aligned");
            foreach (hi[c])
                hi[c] += (cur[c] === 1'b1) ? 1 : 0;
            prev = cur;
        end
        foreach (hi[c])
            check(hi[c] == r.hi[c], "high slot count");
        $display("test pin row done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        logic nack;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = SPW_HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        strap = 1'b0;
        modes = 12'h000;
        invert = 1'b0;
        segs = 6'h00;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        acc = '{8'h70, 8'h80, 8'h3C, 8'hA0, 8'h11, 8'h20, 8'h22, 8'h33};
        access(nack);
        check(nack === 1'b0, "routing access not acked");
        check(cmd_q.size() == 1 && cmd_q[0] === 8'h3C, "command byte");
        check(ram_q.size() == 3 && {ram_q[0], ram_q[1], ram_q[2]} === 24'h112233, "ram");
        acc = '{8'h70, 8'h60, 8'h5A, 8'hA5};
        access(nack);
        check(nack === 1'b0 && cmd_q.size() == 0 && ram_q.size() == 0, "unused code");
        $display("test routing done");
        acc = '{8'h72};
        access(nack);
        check(nack === 1'b1, "foreign address acked");
        acc = '{8'h71};
        access(nack);
        check(nack === 1'b1, "read address acked");
        @(posedge hclk);
        strap <= 1'b1;
        acc = '{8'h72, 8'h00, 8'h44};
        access(nack);
        check(nack === 1'b0 && cmd_q.size() == 1 && cmd_q[0] === 8'h44, "strap address");
        @(posedge hclk);
        strap <= 1'b0;
        $display("test addressing done");
        acc = '{8'h70, 8'h80, SPW_CMD_LOAD_PTR, 8'h40, 8'h63, 8'h01, 8'h40, 8'h7E, 8'h7F,
            8'h05, 8'h00};
        access(nack);
        check(nack === 1'b0, "pwm access not acked");
        foreach (rows[i])
            measure(rows[i]);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        check(pins === 6'h00 && i_spw_link_if.scl === 1'b1 && i_spw_link_if.sda === 1'b1,
            "reset state");
        hresetn <= 1'b1;
        measure('{{6{SPW_MODE_PWM}}, 6'h3F, 1'b0, '{0, 0, 0, 0, 0, 0}});
        $display("test reset done");
        complete_run();
    end
endmodule
